// ---- verilog/occr_regs.sv ----
// Purpose: output and clock configuration register bank
// Assumes: byte register port from the serial control logic, sync pulse on ref_clk
// Notes: read data is registered, one cycle after the read strobe
`timescale 1ns/1ps
// Behaviour
// - format field 00 offset binary, 01 twos complement coding
// - output type bit at 0x14: clear CMOS, set LVDS
// - bit 7 of output mode: clear ANSI swing, set reduced swing
// - phase field at 0x16 delays divider zero to seven input cycles
// - data clock delay equals 2500 ps times code over 31
// - delay field five low bits, code one about 81 ps
// - reference select top two bits, reset 11 giving 0xc0
// - sync register 0x100 bit 2 next-sync-only, all cleared at reset
// - no sync action unless master enable bit 0 set
// - master and divider enable set: every sync pulse reaches divider
// - next-sync-only: align on first pulse, then clear divider enable
module occr_regs (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // register port
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [8:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // converter side inputs
    input wire logic [15:0] selftest_signature,
    input wire logic sync_in,
    input wire logic [2:0] divide_ratio_m1,
    // configuration outputs
    output logic [1:0] output_format,
    output logic output_lvds,
    output logic drive_reduced,
    output logic output_invert,
    output logic output_disable,
    output logic clock_invert,
    output logic [2:0] phase_adjust,
    output logic [4:0] data_clock_delay_code,
    output logic [11:0] data_clock_delay_ps,
    output logic [1:0] reference_select,
    output logic dither_enable,
    output logic divider_tick
);
    typedef struct packed {
        logic [7:0] output_format_control;
        logic [7:0] clock_phase_control;
        logic [7:0] data_clock_delay;
        logic [7:0] reference_range_select;
        logic [7:0] dither_control;
        logic [7:0] sync_control;
        logic [7:0] rdata;
        logic [11:0] delay_ps;
    } occr_state_type;

    occr_state_type state;
    occr_state_type next_state;
    logic sync_accept;
    logic tick;

    ////////////////////////////////////////////////////////////////
    // register map, one byte per address, open bits read as zero
    //
    // output_format_control at 0x014, reset 0x00
    //   bit 7 drive_reduced: set gives the reduced lvds swing
    //   bit 6 output_lvds: set gives lvds, clear gives cmos
    //   bit 5 open
    //   bit 4 output_disable: set turns the data outputs off
    //   bit 3 open
    //   bit 2 output_invert
    //   bits 1:0 output_format, the sample coding
    //     00 offset binary
    //     01 twos complement
    //     10 gray code
    //     11 offset binary again
    //
    // clock_phase_control at 0x016, reset 0x00
    //   bit 7 clock_invert for the output data clock
    //   bits 6:3 open
    //   bits 2:0 phase_adjust, divider hold in input cycles
    //     000 means no hold after an accepted sync
    //     each step adds one input clock cycle, up to seven
    //
    // data_clock_delay at 0x017, reset 0x00
    //   bits 7:5 open
    //   bits 4:0 delay code of the output data clock
    //   delay is 2500 ps times the code over 31, rounded
    //     code 0 gives 0 ps
    //     code 1 gives 81 ps
    //     code 2 gives 161 ps
    //     code 30 gives 2419 ps
    //     code 31 gives the full 2500 ps
    //
    // reference_range_select at 0x018, reset 0xc0
    //   bits 7:6 reference_select, the input full scale
    //     00 gives 1.25 V p-p
    //     01 gives 1.5 V p-p
    //     10 gives 1.75 V p-p
    //     11 gives 2.0 V p-p, the reset choice
    //   bits 5:0 open
    //
    // selftest_signature_low at 0x024, read only
    //   bits 7:0 low byte of the core signature
    // selftest_signature_high at 0x025, read only
    //   bits 7:0 high byte of the core signature
    //   the halves are not latched as a pair, so a host that
    //   reads both while the core updates may see a torn word
    //
    // dither_control at 0x030, reset 0x00
    //   bit 4 dither_enable
    //   all other bits open
    //
    // sync_control at 0x100, reset 0x00
    //   bits 7:3 open
    //   bit 2 next-sync-only, one alignment then bit 1 clears
    //   bit 1 divider sync enable, gates sync to the divider
    //   bit 0 master sync enable, gates every sync function
    //   keep bit 0 clear when sync is unused, to save power
    //
    ////////////////////////////////////////////////////////////////
    // register port timing
    //   a write is taken on the edge that sees reg_write high
    //   the written field shows on its output right after that same edge
    //   a read is taken on the edge that sees reg_read high
    //   reg_rdata is registered and stands until the next read
    //   a read and a write in one cycle return the old value
    //   writes to read-only or unmapped places are dropped
    //   unmapped reads return zero rather than a stale byte
    //
    // delay code and delay in ps are registered together, so
    // a user never sees the code of one write with the ps of
    // the one before; the price is a divider in the write path
    //
    ////////////////////////////////////////////////////////////////
    // sync timing
    //   a pulse on sync_in counts only with bits 0 and 1 set
    //   an accepted pulse restarts the divider at count zero
    //   the divider then holds for phase_adjust cycles
    //   and ticks after divide_ratio_m1 plus one more cycles
    //   with next-sync-only set, the same edge clears bit 1
    //   that hardware clear wins over a same-cycle write,
    //   so a host cannot re-arm by accident in that cycle
    //   later pulses leave the divider running free
    //
    ////////////////////////////////////////////////////////////////
    // read mux, decoded for the bus and nowhere else
    function automatic logic [7:0] occr_read_value(input occr_state_type s, input logic [8:0] a,
                                                   input logic [15:0] sig);
        logic [7:0] v;
        v = 8'h00;
        unique case (a)
            occr_pkg::occr_addr_output_format: v = s.output_format_control;
            occr_pkg::occr_addr_clock_phase: v = s.clock_phase_control;
            occr_pkg::occr_addr_data_clock_delay: v = s.data_clock_delay;
            occr_pkg::occr_addr_reference_range: v = s.reference_range_select;
            occr_pkg::occr_addr_signature_low: v = sig[7:0];
            occr_pkg::occr_addr_signature_high: v = sig[15:8];
            occr_pkg::occr_addr_dither: v = s.dither_control;
            occr_pkg::occr_addr_sync: v = s.sync_control;
            default: v = 8'h00; // unmapped reads zero
        endcase
        return v;
    endfunction : occr_read_value

    // scaled delay in ps, rounded to nearest; truncation would read 80 for code one
    function automatic logic [11:0] occr_delay_of(input logic [4:0] code);
        int p;
        p = (occr_pkg::occr_delay_full_ps * int'(code) + occr_pkg::occr_delay_max_code / 2)
            / occr_pkg::occr_delay_max_code;
        return p[11:0];
    endfunction : occr_delay_of

    ////////////////////////////////////////////////////////////////
    // master gate
    // sync accepted only with master and divider enables both high
    // continuous sync
    assign sync_accept = state.sync_control[occr_pkg::occr_pos_sync_master]
                       && state.sync_control[occr_pkg::occr_pos_sync_divider];

    occr_divider_sync u_divider (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .phase_adjust(state.clock_phase_control[2:0]),
        .divide_ratio_m1(divide_ratio_m1),
        .sync_pulse(sync_in),
        .sync_accept(sync_accept),
        .divider_tick(tick)
    );

    ////////////////////////////////////////////////////////////////
    // register writes, reads and self clearing
    always_comb begin
        next_state = state;
        if (reg_write) begin
            unique case (reg_addr)
                occr_pkg::occr_addr_output_format:
                    next_state.output_format_control = reg_wdata & occr_pkg::occr_mask_output_format;
                occr_pkg::occr_addr_clock_phase:
                    next_state.clock_phase_control = reg_wdata & occr_pkg::occr_mask_clock_phase;
                occr_pkg::occr_addr_data_clock_delay:
                    next_state.data_clock_delay = reg_wdata & occr_pkg::occr_mask_data_clock_delay;
                occr_pkg::occr_addr_reference_range:
                    next_state.reference_range_select = reg_wdata & occr_pkg::occr_mask_reference_range;
                occr_pkg::occr_addr_dither:
                    next_state.dither_control = reg_wdata & occr_pkg::occr_mask_dither;
                occr_pkg::occr_addr_sync:
                    next_state.sync_control = reg_wdata & occr_pkg::occr_mask_sync;
                default: ; // read-only and unmapped writes are ignored
            endcase
        end
        // one-shot sync
        // hardware clear after the first accepted pulse wins over a same-cycle write
        if (sync_in && sync_accept && state.sync_control[occr_pkg::occr_pos_sync_next_only]) begin
            next_state.sync_control[occr_pkg::occr_pos_sync_divider] = 1'b0;
        end
        if (reg_read) begin
            next_state.rdata = occr_read_value(state, reg_addr, selftest_signature);
        end
        next_state.delay_ps = occr_delay_of(next_state.data_clock_delay[4:0]);
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state.output_format_control <= occr_pkg::occr_rst_output_format;
            state.clock_phase_control <= occr_pkg::occr_rst_clock_phase;
            state.data_clock_delay <= occr_pkg::occr_rst_data_clock_delay;
            state.reference_range_select <= occr_pkg::occr_rst_reference_range;
            state.dither_control <= occr_pkg::occr_rst_dither;
            state.sync_control <= occr_pkg::occr_rst_sync;
            state.rdata <= 8'h00;
            state.delay_ps <= 12'h000;
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////
    // outputs, all straight from flip-flops
    // output coding
    assign output_format = state.output_format_control[occr_pkg::occr_pos_format +: 2];
    assign output_lvds = state.output_format_control[occr_pkg::occr_pos_output_lvds];
    assign drive_reduced = state.output_format_control[occr_pkg::occr_pos_drive_reduced];
    assign output_invert = state.output_format_control[occr_pkg::occr_pos_output_invert];
    assign output_disable = state.output_format_control[occr_pkg::occr_pos_output_disable];
    assign clock_invert = state.clock_phase_control[occr_pkg::occr_pos_clock_invert];
    assign phase_adjust = state.clock_phase_control[occr_pkg::occr_pos_phase +: 3];
    assign data_clock_delay_code = state.data_clock_delay[4:0];
    assign data_clock_delay_ps = state.delay_ps;
    assign reference_select = state.reference_range_select[occr_pkg::occr_pos_reference +: 2];
    assign dither_enable = state.dither_control[occr_pkg::occr_pos_dither];
    assign reg_rdata = state.rdata;
    assign divider_tick = tick; // registered inside the divider
endmodule : occr_regs

// ---- verilog/occr_pkg.sv ----
// Purpose: constants for the output and clock configuration register bank
// Assumes: byte-wide registers on a simple internal register port
// Notes: offsets are the printed register addresses
package occr_pkg;
    // register addresses
    localparam logic [8:0] occr_addr_output_format = 9'h014;
    localparam logic [8:0] occr_addr_clock_phase = 9'h016;
    localparam logic [8:0] occr_addr_data_clock_delay = 9'h017;
    localparam logic [8:0] occr_addr_reference_range = 9'h018;
    localparam logic [8:0] occr_addr_signature_low = 9'h024;
    localparam logic [8:0] occr_addr_signature_high = 9'h025;
    localparam logic [8:0] occr_addr_dither = 9'h030;
    localparam logic [8:0] occr_addr_sync = 9'h100;
    // reset values
    localparam logic [7:0] occr_rst_output_format = 8'h00;
    localparam logic [7:0] occr_rst_clock_phase = 8'h00;
    localparam logic [7:0] occr_rst_data_clock_delay = 8'h00;
    localparam logic [7:0] occr_rst_reference_range = 8'hc0;
    localparam logic [7:0] occr_rst_dither = 8'h00;
    localparam logic [7:0] occr_rst_sync = 8'h00;
    // writable bit masks, open bits read as zero
    localparam logic [7:0] occr_mask_output_format = 8'hd7;
    localparam logic [7:0] occr_mask_clock_phase = 8'h87;
    localparam logic [7:0] occr_mask_data_clock_delay = 8'h1f;
    localparam logic [7:0] occr_mask_reference_range = 8'hc0;
    localparam logic [7:0] occr_mask_dither = 8'h10;
    localparam logic [7:0] occr_mask_sync = 8'h07;
    // field positions
    localparam int occr_pos_drive_reduced = 7;
    localparam int occr_pos_output_lvds = 6;
    localparam int occr_pos_output_disable = 4;
    localparam int occr_pos_output_invert = 2;
    localparam int occr_pos_format = 0;
    localparam int occr_pos_clock_invert = 7;
    localparam int occr_pos_phase = 0;
    localparam int occr_pos_reference = 6;
    localparam int occr_pos_dither = 4;
    localparam int occr_pos_sync_master = 0;
    localparam int occr_pos_sync_divider = 1;
    localparam int occr_pos_sync_next_only = 2;
    // output data clock delay: 2500 ps times code over 31
    localparam int occr_delay_full_ps = 2500;
    localparam int occr_delay_max_code = 31;
    // output coding
    typedef enum logic [1:0] {
        occr_fmt_offset_binary = 2'b00,
        occr_fmt_twos_complement = 2'b01,
        occr_fmt_gray = 2'b10,
        occr_fmt_offset_binary_alt = 2'b11
    } occr_format_type;
endpackage : occr_pkg

// ---- verilog/occr_divider_sync.sv ----
// Purpose: input clock divider phase and sync alignment
// Assumes: sync pulse synchronous to ref_clk
// Notes: counts divider cycles and restarts on an accepted sync
`timescale 1ns/1ps
module occr_divider_sync (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // control
    input wire logic [2:0] phase_adjust,
    input wire logic [2:0] divide_ratio_m1,
    input wire logic sync_pulse,
    input wire logic sync_accept,
    // status
    output logic divider_tick
);
    typedef struct packed {
        logic [2:0] count;
        logic [2:0] hold;
        logic tick;
    } occr_div_state_type;

    occr_div_state_type state;
    occr_div_state_type next_state;

    ////////////////////////////////////////////////////////////////
    // phase adjust holds the divider that many cycles after a sync
    always_comb begin
        next_state = state;
        next_state.tick = 1'b0;
        if (sync_pulse && sync_accept) begin
            next_state.count = 3'h0;
            next_state.hold = phase_adjust;
        end else if (state.hold != 3'h0) begin
            next_state.hold = state.hold - 3'h1;
        end else if (state.count == divide_ratio_m1) begin
            next_state.count = 3'h0;
            next_state.tick = 1'b1;
        end else begin
            next_state.count = state.count + 3'h1;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign divider_tick = state.tick;
endmodule : occr_divider_sync

// ---- bench/occr_regs_assertions.sv ----
// Purpose: port checks for occr_regs
// Assumes: one ref_clk domain, writes taken on the strobe edge
// Notes: bound to every occr_regs instance
`timescale 1ns/1ps
module occr_regs_assertions (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // register port
    input wire logic reg_write,
    input wire logic [8:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    // configuration outputs
    input wire logic [1:0] output_format,
    input wire logic output_lvds,
    input wire logic drive_reduced,
    input wire logic output_disable,
    input wire logic [2:0] phase_adjust,
    input wire logic [4:0] data_clock_delay_code,
    input wire logic [11:0] data_clock_delay_ps,
    input wire logic [1:0] reference_select
);
    logic [7:0] last_wdata;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    // write data one edge back, so slices need no $past
    always_ff @(posedge ref_clk) last_wdata <= reg_wdata;
    ////////////////////////////////////////////////////////////////
    format_write_a: assert property (reg_write && reg_addr == 9'h014 |=> output_format == last_wdata[1:0])
        else $error("format not loaded");
    lvds_write_a: assert property (reg_write && reg_addr == 9'h014 |=> output_lvds == last_wdata[6])
        else $error("output type not loaded");
    swing_write_a: assert property (reg_write && reg_addr == 9'h014 |=> drive_reduced == last_wdata[7])
        else $error("drive level not loaded");
    disable_write_a: assert property (reg_write && reg_addr == 9'h014 |=> output_disable == last_wdata[4])
        else $error("output disable not loaded");
    phase_write_a: assert property (reg_write && reg_addr == 9'h016 |=> phase_adjust == last_wdata[2:0])
        else $error("phase adjust not loaded");
    delay_ps_a: assert property (data_clock_delay_ps == (2500 * data_clock_delay_code + 15) / 31)
        else $error("delay in ps off its code");
    delay_code_a: assert property (reg_write && reg_addr == 9'h017 |=> data_clock_delay_code == last_wdata[4:0])
        else $error("delay code not loaded");
    reference_write_a: assert property (reg_write && reg_addr == 9'h018 |=> reference_select == last_wdata[7:6])
        else $error("reference select not loaded");
endmodule : occr_regs_assertions
bind occr_regs occr_regs_assertions i_occr_regs_assertions (.ref_clk(ref_clk), .rstn(rstn),
    .reg_write(reg_write), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .output_format(output_format),
    .output_lvds(output_lvds), .drive_reduced(drive_reduced), .output_disable(output_disable),
    .phase_adjust(phase_adjust), .data_clock_delay_code(data_clock_delay_code),
    .data_clock_delay_ps(data_clock_delay_ps), .reference_select(reference_select));

// ---- bench/occr_host_model.sv ----
// Purpose: host side of the register port
// Assumes: one strobe per access, changed just after an edge
// Notes: idle lines show the inverse so stale values never match
`timescale 1ns/1ps
module occr_host_model (
    // clock
    input wire logic ref_clk,
    // register port
    output logic reg_write = 1'b0,
    output logic reg_read = 1'b0,
    output logic [8:0] reg_addr = 9'h000,
    output logic [7:0] reg_wdata = 8'h00,
    input wire logic [7:0] reg_rdata
);
    // one access: strobe for a single edge, read data taken after it
    task automatic access(input logic wr, input logic [8:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge ref_clk);
        #1;
        reg_write = wr;
        reg_read = !wr;
        reg_addr = a;
        reg_wdata = d;
        @(posedge ref_clk);
        #1;
        q = reg_rdata;
        reg_write = 1'b0;
        reg_read = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask : access
endmodule : occr_host_model

// ---- bench/testbench.sv ----
// Purpose: self-checking bench for occr_regs
// Assumes: host model drives the register port
// Notes: expected values come from an integer register model
`timescale 1ns/1ps
module testbench;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic reg_write, reg_read, sync_in = 1'b0, output_lvds, drive_reduced, output_disable, divider_tick;
    logic output_invert, clock_invert, dither_enable;
    logic [8:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, q;
    logic [15:0] selftest_signature = 16'h0000;
    logic [2:0] divide_ratio_m1 = 3'h7, phase_adjust;
    logic [1:0] output_format, reference_select;
    logic [4:0] data_clock_delay_code;
    logic [11:0] data_clock_delay_ps;
    int failures = 0, tests_run = 0, cycles = 0, t, model[int];
    int addrs[9] = '{'h14, 'h16, 'h17, 'h18, 'h24, 'h25, 'h30, 'h100, 'hff};
    int masks[int] = '{'h14: 'hd7, 'h16: 'h87, 'h17: 'h1f, 'h18: 'hc0, 'h30: 'h10, 'h100: 'h07};
    int syncs[3][2] = '{'{'h06, 'h06}, '{'h03, 'h03}, '{'h07, 'h05}};
    always #2 ref_clk = ~ref_clk;
    occr_host_model i_occr_host_model (.ref_clk(ref_clk), .reg_write(reg_write), .reg_read(reg_read),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
    occr_regs i_occr_regs (.ref_clk(ref_clk), .rstn(rstn), .reg_write(reg_write), .reg_read(reg_read),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .selftest_signature(selftest_signature),
        .sync_in(sync_in), .divide_ratio_m1(divide_ratio_m1), .output_format(output_format),
        .output_lvds(output_lvds), .drive_reduced(drive_reduced), .output_invert(output_invert),
        .output_disable(output_disable), .clock_invert(clock_invert), .phase_adjust(phase_adjust),
        .data_clock_delay_code(data_clock_delay_code), .data_clock_delay_ps(data_clock_delay_ps),
        .reference_select(reference_select), .dither_enable(dither_enable),
        .divider_tick(divider_tick));
    ////////////////////////////////////////////////////////////////
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : stop_test
    // a runaway bench counts as a mismatch
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            stop_test();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // write, keeping the model in step; read-only and open places ignore it
    task automatic wr(input int a, input int d);
        i_occr_host_model.access(1'b1, a[8:0], d[7:0], q);
        if (masks.exists(a)) model[a] = d & masks[a];
    endtask : wr
    task automatic rd_check(input int a);
        i_occr_host_model.access(1'b0, a[8:0], 8'h00, q);
        if (a == 'h24 || a == 'h25) check(q, a == 'h24 ? selftest_signature[7:0] : selftest_signature[15:8]);
        else check(q, model.exists(a) ? model[a] : 0);
    endtask : rd_check
    task automatic outs;
        check(output_format, model['h14] & 3);
        check(output_lvds, model['h14] >> 6 & 1);
        check(drive_reduced, model['h14] >> 7);
        check(output_disable, model['h14] >> 4 & 1);
        check(output_invert, model['h14] >> 2 & 1);
        check(clock_invert, model['h16] >> 7);
        check(dither_enable, model['h30] >> 4 & 1);
        check(phase_adjust, model['h16] & 7);
        check(data_clock_delay_code, model['h17]);
        check(data_clock_delay_ps, (2500 * model['h17] + 15) / 31);
        check(reference_select, model['h18] >> 6);
    endtask : outs
    // one sync pulse, then cycles until the next divider tick
    task automatic pulse_sync;
        @(posedge ref_clk);
        #1 sync_in = 1'b1;
        @(posedge ref_clk);
        #1 sync_in = 1'b0;
        for (t = 1; t < 40 && divider_tick !== 1'b1; t++) @(posedge ref_clk) #1;
    endtask : pulse_sync
    // load the reset image into the model and read every place back
    task automatic check_defaults;
        model = '{'h14: 0, 'h16: 0, 'h17: 0, 'h18: 'hc0, 'h30: 0, 'h100: 0};
        foreach (addrs[i]) rd_check(addrs[i]);
        outs();
    endtask : check_defaults
    ////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(89359));
        repeat (5) @(posedge ref_clk);
        #1 rstn = 1'b1;
        check_defaults();
        $display("test reset values done");
        for (int i = 0; i < 60; i++) begin
            selftest_signature = 16'($urandom);
            wr(addrs[$urandom % 9], $urandom);
            rd_check(addrs[$urandom % 9]);
            outs();
        end
        $display("test random access done");
        for (int c = 0; c < 32; c++) begin
            wr('h17, c);
            outs();
        end
        $display("test delay codes done");
        wr('h16, 'h07);
        foreach (syncs[i]) begin
            wr('h100, syncs[i][0]);
            pulse_sync();
            // accepted: 7 hold cycles and 8 count cycles after the sync edge; refused: free run ticks within 8
            if ((syncs[i][0] & 3) == 3) check(t, 16);
            else check(t <= 8, 1);
            pulse_sync();
            // the second pulse aligns only while continuous sync is still enabled
            if ((syncs[i][1] & 3) == 3) check(t, 16);
            else check(t <= 8, 1);
            model['h100] = syncs[i][1];
            rd_check('h100);
        end
        $display("test sync control done");
        // mid-run reset with sync bits, phase and delay code left set
        @(posedge ref_clk);
        #1 rstn = 1'b0;
        @(posedge ref_clk);
        #1 rstn = 1'b1;
        check_defaults();
        $display("test mid-run reset done");
        stop_test();
    end
endmodule : testbench
